// file: verilog/pi_mode_switch_feedforward.sv
// Purpose: speed detection select, position feedforward and P/PI mode switch
// Assumes: AHB-Lite slave, single word transfers, zero wait states
// Notes: process inputs come from logic on i_mclk
//
// Design decisions made here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/100ps
`include "servo_tune_consts.svh"
// Notes on behaviour
// RL1: speed detection method latched on restart only
// RL2: feedforward gain and lag filter, applied immediately
// RL3: software keeps feedforward gain at 80% or less
// RL4: speed loop switches between P and PI
// RL5: digit zero picks condition; force by default
// RL6: code 1 compares speed reference against threshold
// RL7: code 2 compares acceleration against threshold
// RL8: code 3 compares position error against threshold
// RL9: code 4 keeps PI, no switching
// RL10: force above threshold selects P control
// RL11: force threshold 0 to 800, default 200
// RL12: speed reference above threshold selects P
// RL13: acceleration above threshold selects P
// RL14: position error above threshold, position control only
// RL15: at or below threshold returns to PI
module pi_mode_switch_feedforward
	import servo_tune_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	input wire logic i_soft_restart,
	input wire logic i_pos_ctrl,
	input wire logic signed [15:0] i_force_ref,
	input wire logic signed [15:0] i_speed_ref,
	input wire logic signed [15:0] i_accel,
	input wire logic signed [23:0] i_pos_err,
	input wire logic signed [15:0] i_pos_ref_delta,
	output logic o_p_control,
	output logic o_speed_detect_sel,
	output logic signed [15:0] o_ff_out,
	output logic o_ctrl_tick
);

	////////////////////////////////////////////////////////////////
	// helpers
	function automatic reg_idx_t reg_decode(input logic [31:0] a);
		if (a[31:6] != 26'h000_0000 || a[1:0] != 2'h0 || a[5:2] > 4'h9) begin
			reg_decode = 4'hf;
		end else begin
			reg_decode = a[5:2];
		end
	endfunction

	function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] mx);
		clamp = (v > mx) ? mx : v;
	endfunction

	function automatic logic [3:0] digit_clamp(input logic [3:0] v, input logic [3:0] mx);
		digit_clamp = (v > mx) ? mx : v;
	endfunction

	function automatic logic [23:0] mag(input logic signed [23:0] v);
		mag = v[23] ? 24'(-v) : 24'(v);
	endfunction

	////////////////////////////////////////////////////////////////
	// bus phase
	logic dp_write_r, dp_write_nxt;
	reg_idx_t dp_idx_r, dp_idx_nxt;
	logic [31:0] hrdata_r, hrdata_nxt;
	logic hreadyout_r;
	logic hresp_r;
	logic addr_phase;
	reg_idx_t ap_idx;

	// configuration
	logic [15:0] spd_param_r, spd_param_nxt;
	logic [6:0] ff_gain_r, ff_gain_nxt;
	logic [12:0] ff_tc_r, ff_tc_nxt;
	logic [15:0] sw_sel_r, sw_sel_nxt;
	logic [9:0] force_thr_r, force_thr_nxt;
	logic [13:0] speed_thr_r, speed_thr_nxt;
	logic [14:0] accel_thr_r, accel_thr_nxt;
	logic [13:0] perr_thr_r, perr_thr_nxt;

	// block state
	logic spd_method_r, spd_method_nxt;
	logic p_ctrl_r, p_ctrl_nxt;
	logic [7:0] tick_cnt_r, tick_cnt_nxt;
	logic tick_r, tick_nxt;
	sample_t ff_out_r;
	logic signed [36:0] ff_prod;
	sample_t ff_raw;
	logic [3:0] sw_code;

	ff_filter_if ffi ();

	////////////////////////////////////////////////////////////////
	// ahb-lite slave, registers
	assign addr_phase = i_hsel && i_htrans[1] && i_hready;
	assign ap_idx = reg_decode(i_haddr);

	always_comb begin
		dp_write_nxt = addr_phase && i_hwrite;
		dp_idx_nxt = addr_phase ? ap_idx : 4'hf;
		spd_param_nxt = spd_param_r;
		ff_gain_nxt = ff_gain_r;
		ff_tc_nxt = ff_tc_r;
		sw_sel_nxt = sw_sel_r;
		force_thr_nxt = force_thr_r;
		speed_thr_nxt = speed_thr_r;
		accel_thr_nxt = accel_thr_r;
		perr_thr_nxt = perr_thr_r;
		if (dp_write_r) begin
			case (dp_idx_r)
				4'(`OFS_SPD_DETECT >> 2): spd_param_nxt = {i_hwdata[15:12],
					digit_clamp(i_hwdata[11:8], `SPD_METHOD_MAX), i_hwdata[7:0]};
				4'(`OFS_FF_GAIN >> 2): ff_gain_nxt = 7'(clamp(i_hwdata, `MAX_FF_GAIN)); // RL2
				4'(`OFS_FF_TC >> 2): ff_tc_nxt = 13'(clamp(i_hwdata, `MAX_FF_TC)); // RL2
				4'(`OFS_SW_SELECT >> 2): sw_sel_nxt = {i_hwdata[15:4],
					digit_clamp(i_hwdata[3:0], `SW_NONE)}; // RL5
				4'(`OFS_FORCE_THR >> 2): force_thr_nxt = 10'(clamp(i_hwdata, `MAX_FORCE_THR)); // RL11
				4'(`OFS_SPEED_THR >> 2): speed_thr_nxt = 14'(clamp(i_hwdata, `MAX_SPEED_THR)); // RL6
				4'(`OFS_ACCEL_THR >> 2): accel_thr_nxt = 15'(clamp(i_hwdata, `MAX_ACCEL_THR)); // RL7
				4'(`OFS_PERR_THR >> 2): perr_thr_nxt = 14'(clamp(i_hwdata, `MAX_PERR_THR)); // RL8
				default: ;
			endcase
		end
		hrdata_nxt = 32'h0000_0000;
		if (addr_phase && !i_hwrite) begin
			case (ap_idx)
				4'(`OFS_SPD_DETECT >> 2): hrdata_nxt = {16'h0000, spd_param_nxt};
				4'(`OFS_FF_GAIN >> 2): hrdata_nxt = {25'h000_0000, ff_gain_nxt};
				4'(`OFS_FF_TC >> 2): hrdata_nxt = {19'h0_0000, ff_tc_nxt};
				4'(`OFS_SW_SELECT >> 2): hrdata_nxt = {16'h0000, sw_sel_nxt};
				4'(`OFS_FORCE_THR >> 2): hrdata_nxt = {22'h00_0000, force_thr_nxt};
				4'(`OFS_SPEED_THR >> 2): hrdata_nxt = {18'h0_0000, speed_thr_nxt};
				4'(`OFS_ACCEL_THR >> 2): hrdata_nxt = {17'h0_0000, accel_thr_nxt};
				4'(`OFS_PERR_THR >> 2): hrdata_nxt = {18'h0_0000, perr_thr_nxt};
				4'(`OFS_STATUS >> 2): hrdata_nxt = {29'h0000_0000, i_pos_ctrl, spd_method_r, p_ctrl_r};
				4'(`OFS_FF_OUT >> 2): hrdata_nxt = {{16{ff_out_r[15]}}, ff_out_r};
				default: hrdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			dp_write_r <= 1'b0;
			dp_idx_r <= 4'hf;
			hrdata_r <= 32'h0000_0000;
			hreadyout_r <= 1'b1;
			hresp_r <= 1'b0;
			spd_param_r <= `RST_PARAM;
			ff_gain_r <= `RST_FF_GAIN;
			ff_tc_r <= `RST_FF_TC;
			sw_sel_r <= `RST_PARAM;
			force_thr_r <= `RST_FORCE_THR;
			speed_thr_r <= `RST_SPEED_THR;
			accel_thr_r <= `RST_ACCEL_THR;
			perr_thr_r <= `RST_PERR_THR;
		end else begin
			dp_write_r <= dp_write_nxt;
			dp_idx_r <= dp_idx_nxt;
			hrdata_r <= hrdata_nxt;
			hreadyout_r <= 1'b1;
			hresp_r <= 1'b0;
			spd_param_r <= spd_param_nxt;
			ff_gain_r <= ff_gain_nxt;
			ff_tc_r <= ff_tc_nxt;
			sw_sel_r <= sw_sel_nxt;
			force_thr_r <= force_thr_nxt;
			speed_thr_r <= speed_thr_nxt;
			accel_thr_r <= accel_thr_nxt;
			perr_thr_r <= perr_thr_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// speed detection method, mode switch, control tick
	assign sw_code = sw_sel_r[`SW_DIGIT_LSB +: 4];

	always_comb begin
		spd_method_nxt = i_soft_restart ? spd_param_r[`SPD_DIGIT_LSB] : spd_method_r; // RL1
		case (sw_code) // RL4 RL5
			`SW_FORCE: p_ctrl_nxt = mag(24'(i_force_ref)) > {14'h0000, force_thr_r}; // RL10 RL15
			`SW_SPEED: p_ctrl_nxt = mag(24'(i_speed_ref)) > {10'h000, speed_thr_r}; // RL12 RL15
			`SW_ACCEL: p_ctrl_nxt = mag(24'(i_accel)) > {9'h000, accel_thr_r}; // RL13 RL15
			`SW_PERR: p_ctrl_nxt = i_pos_ctrl && (mag(i_pos_err) > {10'h000, perr_thr_r}); // RL14 RL15
			default: p_ctrl_nxt = 1'b0; // RL9
		endcase
		tick_nxt = (tick_cnt_r == 8'(`CTRL_CYCLE_CLKS - 1));
		tick_cnt_nxt = tick_nxt ? 8'h00 : tick_cnt_r + 8'h01;
	end

	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			spd_method_r <= 1'b0;
			p_ctrl_r <= 1'b0;
			tick_cnt_r <= 8'h00;
			tick_r <= 1'b0;
		end else begin
			spd_method_r <= spd_method_nxt;
			p_ctrl_r <= p_ctrl_nxt;
			tick_cnt_r <= tick_cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// feedforward: gain in percent, then lag filter
	always_comb begin
		ff_prod = $signed(37'(i_pos_ref_delta)) * $signed({30'h0000_0000, ff_gain_r}) * $signed(`FF_RECIP); // RL2
		ff_raw = ff_prod[`FF_RECIP_SHIFT +: 16];
	end

	assign ffi.start = tick_r && !ffi.busy; // RL2
	assign ffi.x = ff_raw;
	assign ffi.tc = ff_tc_r;

	ff_lag_filter u_filter (
		.i_mclk(i_mclk),
		.i_nrst(i_nrst),
		.ffi(ffi)
	);

	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			ff_out_r <= 16'h0000;
		end else begin
			ff_out_r <= ffi.y;
		end
	end

	assign o_hrdata = hrdata_r;
	assign o_hreadyout = hreadyout_r;
	assign o_hresp = hresp_r;
	assign o_p_control = p_ctrl_r;
	assign o_speed_detect_sel = spd_method_r;
	assign o_ff_out = ff_out_r;
	assign o_ctrl_tick = tick_r;

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);

	AST_METHOD_HOLD: assert property (!i_soft_restart |=> $stable(o_speed_detect_sel)) // RL1
		else $error("speed detection method changed without restart");
	AST_METHOD_LOAD: assert property (i_soft_restart |=> o_speed_detect_sel == $past(spd_param_r[8])) // RL1
		else $error("speed detection method not loaded at restart");
	AST_FF_PASS: assert property ((tick_r && !ffi.busy && ff_tc_r == 13'h0000) |=> ##1 o_ff_out == $past(ff_raw, 2)) // RL2
		else $error("feedforward with zero time constant not passed through");
	AST_FF_LIMITS: assert property (ff_gain_r <= 7'h64 && ff_tc_r <= 13'h1900) // RL2
		else $error("feedforward setting out of range");
	AST_FORCE_P: assert property ((sw_code == 4'h0 && mag(24'(i_force_ref)) > {14'h0000, force_thr_r}) |=> o_p_control) // RL10
		else $error("force above threshold without P control");
	AST_FORCE_THR: assert property (force_thr_r <= 10'h320) // RL11
		else $error("force threshold out of range");
	AST_SPEED_P: assert property ((sw_code == 4'h1 && mag(24'(i_speed_ref)) > {10'h000, speed_thr_r}) |=> o_p_control) // RL12
		else $error("speed above threshold without P control");
	AST_ACCEL_P: assert property ((sw_code == 4'h2 && mag(24'(i_accel)) > {9'h000, accel_thr_r}) |=> o_p_control) // RL13
		else $error("acceleration above threshold without P control");
	AST_PERR_POS: assert property ((sw_code == 4'h3 && !i_pos_ctrl) |=> !o_p_control) // RL14
		else $error("position error condition outside position control");
	AST_CODE4_PI: assert property (sw_code == 4'h4 [*2] |-> ##1 !o_p_control) // RL9
		else $error("mode switch disabled but P control selected");
	AST_RESTORE_PI: assert property ((sw_code == 4'h0 && mag(24'(i_force_ref)) <= {14'h0000, force_thr_r}) // RL15
		|=> !o_p_control)
		else $error("PI not restored below threshold");
	AST_TICK_SPACING: assert property (tick_r |=> !tick_r [*8]) // RL15
		else $error("control ticks too close");

	////////////////////////////////////////////////////////////////
	// control cycle period
	logic [7:0] since_tick_r, since_tick_nxt;

	always_comb begin
		since_tick_nxt = tick_r ? 8'h00 : since_tick_r + 8'h01;
	end

	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			since_tick_r <= 8'hff;
		end else begin
			since_tick_r <= since_tick_nxt;
		end
	end

	AST_TICK_PERIOD: assert property (tick_r == (since_tick_r == 8'(`CTRL_CYCLE_CLKS - 1))) // RL15
		else $error("control tick period wrong");

	// mode switch, remaining conditions
	AST_SPEED_PI: assert property ((sw_code == 4'h1 && mag(24'(i_speed_ref)) <= {10'h000, speed_thr_r}) // RL15
		|=> !o_p_control)
		else $error("PI not restored below speed threshold");
	AST_ACCEL_PI: assert property ((sw_code == 4'h2 && mag(24'(i_accel)) <= {9'h000, accel_thr_r}) // RL15
		|=> !o_p_control)
		else $error("PI not restored below acceleration threshold");
	AST_PERR_P: assert property ((sw_code == 4'h3 && i_pos_ctrl && mag(i_pos_err) > {10'h000, perr_thr_r}) // RL14
		|=> o_p_control)
		else $error("position error above threshold without P control");
	AST_PERR_PI: assert property ((sw_code == 4'h3 && mag(i_pos_err) <= {10'h000, perr_thr_r}) // RL15
		|=> !o_p_control)
		else $error("PI not restored below position error threshold");
	AST_P_NEEDS_SWITCH: assert property (o_p_control |-> $past(sw_code) != 4'h4) // RL4
		else $error("P control while switching disabled");
	AST_STATUS_READ: assert property ((addr_phase && !i_hwrite && ap_idx == 4'h8) // RL4
		|=> o_hrdata[0] == $past(p_ctrl_r))
		else $error("status read does not show the loop mode");

	// settings
	AST_SW_CODE_RANGE: assert property (sw_code <= 4'h4) // RL5
		else $error("switch condition code out of range");
	AST_SW_IMMEDIATE: assert property ((dp_write_r && dp_idx_r == 4'h3 && i_hwdata[3:0] <= 4'h4) // RL5
		|=> sw_code == $past(i_hwdata[3:0]))
		else $error("switch condition not applied at once");
	AST_SPD_DIGIT_RANGE: assert property (spd_param_r[11:8] <= 4'h1) // RL1
		else $error("speed detection digit out of range");
	AST_GAIN_IMMEDIATE: assert property ((dp_write_r && dp_idx_r == 4'h1 && i_hwdata <= 32'h0000_0064) // RL2
		|=> ff_gain_r == $past(i_hwdata[6:0]))
		else $error("feedforward gain not applied at once");
	AST_FORCE_IMMEDIATE: assert property ((dp_write_r && dp_idx_r == 4'h4 && i_hwdata <= 32'h0000_0320) // RL11
		|=> force_thr_r == $past(i_hwdata[9:0]))
		else $error("force threshold not applied at once");
	AST_FORCE_CLAMP: assert property ((dp_write_r && dp_idx_r == 4'h4 && i_hwdata > 32'h0000_0320) // RL11
		|=> force_thr_r == 10'h320)
		else $error("force threshold not clamped");
	AST_THR_LIMITS: assert property (speed_thr_r <= 14'h2710 && accel_thr_r <= 15'h7530 && perr_thr_r <= 14'h2710) // RL6 RL7 RL8
		else $error("threshold out of range");

	// feedforward lag
	AST_FF_ZERO_GAIN: assert property (ff_gain_r == 7'h00 |-> ff_raw == 16'sh0000) // RL2
		else $error("feedforward not zero with zero gain");
	AST_FILT_BUSY: assert property ((ffi.start && ffi.tc != 13'h0000) |=> ffi.busy) // RL2
		else $error("lag filter did not start");
	AST_FILT_DONE: assert property ((ffi.start && ffi.tc != 13'h0000) |-> ##18 !ffi.busy) // RL2
		else $error("lag filter did not finish in time");

	COV_FORCE_P: cover property (sw_code == 4'h0 ##1 o_p_control);
	COV_PERR_P: cover property (sw_code == 4'h3 && i_pos_ctrl ##1 o_p_control);
	COV_RESTART: cover property (i_soft_restart ##1 o_speed_detect_sel);
	COV_FF_FILTER: cover property (ffi.start && ff_tc_r != 13'h0000);
	COV_SPEED_P: cover property (sw_code == 4'h1 ##1 o_p_control);

endmodule

// file: verilog/servo_tune_consts.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 32-bit AHB-Lite words, byte offsets below 0x40
// Notes: ranges are upper clamp limits applied on write
`ifndef SERVO_TUNE_CONSTS_SVH
`define SERVO_TUNE_CONSTS_SVH

// register byte offsets
`define OFS_SPD_DETECT 8'h00
`define OFS_FF_GAIN 8'h04
`define OFS_FF_TC 8'h08
`define OFS_SW_SELECT 8'h0c
`define OFS_FORCE_THR 8'h10
`define OFS_SPEED_THR 8'h14
`define OFS_ACCEL_THR 8'h18
`define OFS_PERR_THR 8'h1c
`define OFS_STATUS 8'h20
`define OFS_FF_OUT 8'h24

// digit fields
`define SPD_DIGIT_LSB 8
`define SW_DIGIT_LSB 0
`define SPD_METHOD_MAX 4'h1
`define SW_FORCE 4'h0
`define SW_SPEED 4'h1
`define SW_ACCEL 4'h2
`define SW_PERR 4'h3
`define SW_NONE 4'h4

// reset values
`define RST_PARAM 16'h0000
`define RST_FF_GAIN 7'h00
`define RST_FF_TC 13'h0000
`define RST_FORCE_THR 10'h0c8
`define RST_SPEED_THR 14'h0000
`define RST_ACCEL_THR 15'h0000
`define RST_PERR_THR 14'h0000

// setting limits
`define MAX_FF_GAIN 32'h0000_0064
`define MAX_FF_TC 32'h0000_1900
`define MAX_FORCE_THR 32'h0000_0320
`define MAX_SPEED_THR 32'h0000_2710
`define MAX_ACCEL_THR 32'h0000_7530
`define MAX_PERR_THR 32'h0000_2710

// gain in percent: x * g / 100 as x * g * 1311 >> 17
`define FF_RECIP 37'h0_0000_051f
`define FF_RECIP_SHIFT 17

// control cycle timing
`define CLK_PERIOD_NS 50
`define CTRL_CYCLE_NS 10000
`define CTRL_CYCLE_CLKS (`CTRL_CYCLE_NS / `CLK_PERIOD_NS)
`define DIV_STEPS 5'h11

`endif

// file: verilog/servo_tune_pkg.sv
// Purpose: shared types of the servo tuning block
// Assumes: nothing beyond the constants header
// Notes: types only
package servo_tune_pkg;
	typedef logic signed [15:0] sample_t;
	typedef logic [3:0] reg_idx_t;
	typedef enum logic {FILT_IDLE, FILT_DIV} filt_state_t;
endpackage

// file: verilog/ff_filter_if.sv
// Purpose: link between the controller and the feedforward lag filter
// Assumes: one clock domain
// Notes: start is a one-cycle pulse
`timescale 1ns/100ps
interface ff_filter_if;
	logic start;
	servo_tune_pkg::sample_t x;
	logic [12:0] tc;
	servo_tune_pkg::sample_t y;
	logic busy;
	modport ctrl (output start, output x, output tc, input y, input busy);
	modport filt (input start, input x, input tc, output y, output busy);
endinterface

// file: verilog/ff_lag_filter.sv
// Purpose: first-order lag, y += (x - y) / (tc + 1) per start
// Assumes: starts spaced more than 18 cycles apart
// Notes: tc of zero passes x straight through
`timescale 1ns/100ps
`include "servo_tune_consts.svh"
module ff_lag_filter
	import servo_tune_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_nrst,
	ff_filter_if.filt ffi
);

	filt_state_t state_r, state_nxt;
	sample_t y_r, y_nxt;
	logic [16:0] dvd_r, dvd_nxt;
	logic [13:0] rem_r, rem_nxt;
	logic [13:0] dsr_r, dsr_nxt;
	logic neg_r, neg_nxt;
	logic [4:0] cnt_r, cnt_nxt;
	logic signed [16:0] diff;
	logic [13:0] rem_sh;

	////////////////////////////////////////////////////////////////
	always_comb begin
		state_nxt = state_r;
		y_nxt = y_r;
		dvd_nxt = dvd_r;
		rem_nxt = rem_r;
		dsr_nxt = dsr_r;
		neg_nxt = neg_r;
		cnt_nxt = cnt_r;
		diff = 17'(ffi.x) - 17'(y_r);
		rem_sh = {rem_r[12:0], dvd_r[16]};
		case (state_r)
			FILT_IDLE: begin
				if (ffi.start) begin
					if (ffi.tc == 13'h0000) begin
						y_nxt = ffi.x;
					end else begin
						neg_nxt = diff[16];
						dvd_nxt = diff[16] ? 17'(-diff) : 17'(diff);
						dsr_nxt = {1'b0, ffi.tc} + 14'h0001;
						rem_nxt = 14'h0000;
						cnt_nxt = `DIV_STEPS;
						state_nxt = FILT_DIV;
					end
				end
			end
			FILT_DIV: begin
				if (rem_sh >= dsr_r) begin
					rem_nxt = rem_sh - dsr_r;
					dvd_nxt = {dvd_r[15:0], 1'b1};
				end else begin
					rem_nxt = rem_sh;
					dvd_nxt = {dvd_r[15:0], 1'b0};
				end
				cnt_nxt = cnt_r - 5'h01;
				if (cnt_r == 5'h01) begin
					y_nxt = neg_r ? 16'(y_r - 16'(dvd_nxt)) : 16'(y_r + 16'(dvd_nxt));
					state_nxt = FILT_IDLE;
				end
			end
			default: state_nxt = FILT_IDLE;
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_r <= FILT_IDLE;
			y_r <= 16'h0000;
			dvd_r <= 17'h0_0000;
			rem_r <= 14'h0000;
			dsr_r <= 14'h0001;
			neg_r <= 1'b0;
			cnt_r <= 5'h00;
		end else begin
			state_r <= state_nxt;
			y_r <= y_nxt;
			dvd_r <= dvd_nxt;
			rem_r <= rem_nxt;
			dsr_r <= dsr_nxt;
			neg_r <= neg_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign ffi.y = y_r;
	assign ffi.busy = (state_r != FILT_IDLE);

endmodule

// file: test/motion_host_model.sv
// Purpose: host side source of motion and position references
// Assumes: one clock; values change by non-blocking assignment after an edge
// Notes: behavioural; the bench calls its tasks just after a rising edge
`timescale 1ns/100ps
module motion_host_model (
	input wire logic i_mclk,
	output logic o_pos_ctrl,
	output logic signed [15:0] o_force_ref,
	output logic signed [15:0] o_speed_ref,
	output logic signed [15:0] o_accel,
	output logic signed [23:0] o_pos_err,
	output logic signed [15:0] o_pos_ref_delta
);
////////////////////////////////////////////////////////////////////////////////
	initial begin
		o_pos_ctrl = 1'b0;
		o_force_ref = 16'sh0000;
		o_speed_ref = 16'sh0000;
		o_accel = 16'sh0000;
		o_pos_err = 24'sh000000;
		o_pos_ref_delta = 16'sh0000;
	end
	// process levels, held until the next call
	task automatic set_refs(input logic pc, input logic signed [15:0] f, input logic signed [15:0] s,
		input logic signed [15:0] a, input logic signed [23:0] e);
		o_pos_ctrl <= pc;
		o_force_ref <= f;
		o_speed_ref <= s;
		o_accel <= a;
		o_pos_err <= e;
	endtask
	// position reference step per control cycle
	task automatic set_delta(input logic signed [15:0] d);
		o_pos_ref_delta <= d;
	endtask
endmodule

// file: test/tb_top.sv
// Purpose: self-checking bench for the mode switch and feedforward block
// Assumes: zero-wait AHB-Lite slave, 20 MHz clock
// Notes: integer model of switch and lag filter computed in the bench
`timescale 1ns/100ps
`include "servo_tune_consts.svh"
module tb_top;
	logic mclk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, soft_restart = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, exp;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, p_control, speed_sel, ctrl_tick, pos_ctrl, pc;
	logic signed [15:0] ff_out, force_ref, speed_ref, accel, pos_ref_delta;
	logic signed [23:0] pos_err;
	integer err_total = 0, checked = 0, seed = 32'h9930, i, k, t, n, y, x, code;
	integer v [0:4];
	integer ofs [0:5] = '{32'h04, 32'h08, 32'h10, 32'h14, 32'h18, 32'h1c};
	integer lim [0:5] = '{`MAX_FF_GAIN, `MAX_FF_TC, `MAX_FORCE_THR, `MAX_SPEED_THR, `MAX_ACCEL_THR, `MAX_PERR_THR};
	integer dflt [0:7] = '{0, 0, 0, 0, 32'hc8, 0, 0, 0};
////////////////////////////////////////////////////////////////////////////////
	always #25 mclk = ~mclk;
	pi_mode_switch_feedforward i_dut (.i_mclk(mclk), .i_nrst(nrst), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hreadyout),
		.o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp), .i_soft_restart(soft_restart),
		.i_pos_ctrl(pos_ctrl), .i_force_ref(force_ref), .i_speed_ref(speed_ref), .i_accel(accel),
		.i_pos_err(pos_err), .i_pos_ref_delta(pos_ref_delta), .o_p_control(p_control),
		.o_speed_detect_sel(speed_sel), .o_ff_out(ff_out), .o_ctrl_tick(ctrl_tick));
	motion_host_model i_host (.i_mclk(mclk), .o_pos_ctrl(pos_ctrl), .o_force_ref(force_ref),
		.o_speed_ref(speed_ref), .o_accel(accel), .o_pos_err(pos_err), .o_pos_ref_delta(pos_ref_delta));
////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
		checked++;
		if (seen !== want) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", name, want, seen);
		end
	endtask
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// one single transfer; entered just after a rising edge
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] q);
		integer w;
		w = 0;
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= wr;
		@(posedge mclk);
		while (hreadyout !== 1'b1 && w < 100) begin
			w++;
			@(posedge mclk);
		end
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge mclk);
		while (hreadyout !== 1'b1 && w < 100) begin
			w++;
			@(posedge mclk);
		end
		q = hrdata;
		check("bus response", {31'h0, hresp}, 32'h0);
		if (w >= 100)
			err_total++;
	endtask
	task automatic wait_tick;
		n = 0;
		@(posedge mclk);
		while (ctrl_tick !== 1'b1 && n < 300) begin
			n++;
			@(posedge mclk);
		end
	endtask
	function automatic integer mag(input integer a);
		return (a < 0) ? -a : a;
	endfunction
////////////////////////////////////////////////////////////////////////////////
	initial begin
		#(20000 * 50);
		err_total++;
		end_of_test;
	end
	initial begin
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		check("p_control", {31'h0, p_control}, 32'h0);
		check("ff_out", 32'(ff_out), 32'h0);
		for (i = 0; i < 8; i++) begin
			bus(1'b0, 4 * i, 32'h0, rd);
			check("reset value", rd, dflt[i]);
		end
		for (i = 0; i < 6; i++) begin
			bus(1'b1, ofs[i], 32'h0000_ffff, rd);
			bus(1'b0, ofs[i], 32'h0, rd);
			check("range limit", rd, lim[i]);
		end
		bus(1'b0, 32'h28, 32'h0, rd);
		check("unmapped", rd, 32'h0);
		bus(1'b1, 32'h0c, 32'hf, rd);
		bus(1'b0, 32'h0c, 32'h0, rd);
		check("switch select", rd, 32'h4);
		// speed method follows the parameter only at restart
		bus(1'b1, 32'h00, 32'h100, rd);
		repeat (3) @(posedge mclk);
		check("speed_sel", {31'h0, speed_sel}, 32'h0);
		soft_restart <= 1'b1;
		@(posedge mclk);
		soft_restart <= 1'b0;
		@(posedge mclk);
		check("speed_sel", {31'h0, speed_sel}, 32'h1);
		// random levels over every switch condition
		for (i = 0; i < 60; i++) begin
			code = i % 5;
			t = $random(seed) & 32'h1ff;
			for (k = 0; k < 5; k++)
				v[k] = (i % 6 == 0) ? t : $random(seed) % 1024;
			pc = 1'($random(seed));
			bus(1'b1, 32'h0c, code, rd);
			for (k = 0; k < 4; k++)
				bus(1'b1, 32'h10 + 4 * k, t, rd);
			i_host.set_refs(pc, 16'(v[0]), 16'(v[1]), 16'(v[2]), 24'(v[3]));
			repeat (2) @(posedge mclk);
			exp = (code == 4 || (code == 3 && !pc)) ? 32'h0 : 32'(mag(v[code]) > t);
			check("p_control", {31'h0, p_control}, exp);
			bus(1'b0, 32'h20, 32'h0, rd);
			check("status", rd & 32'h5, {29'h0, pc, 1'b0, exp[0]});
		end
		// feedforward, direct then through the lag
		i_host.set_delta(16'sd1000);
		bus(1'b1, 32'h04, 32'd50, rd);
		bus(1'b1, 32'h08, 32'd0, rd);
		wait_tick;
		wait_tick;
		check("tick spacing", n, 199);
		repeat (3) @(posedge mclk);
		y = (1000 * 50 * 1311) >>> 17;
		check("ff_out", 32'(ff_out), y);
		bus(1'b1, 32'h04, 32'd80, rd);
		bus(1'b1, 32'h08, 32'd1, rd);
		x = (1000 * 80 * 1311) >>> 17;
		for (i = 0; i < 3; i++) begin
			wait_tick;
			repeat (22) @(posedge mclk);
			y = y + (x - y) / 2;
			check("ff_out", 32'(ff_out), y);
		end
		bus(1'b0, 32'h24, 32'h0, rd);
		check("ff register", rd, y);
		end_of_test;
	end
endmodule
